// ---- hw/vgapr_pkg.sv ----
// package for the legacy palette/sequencer register set
// assumes an 8-bit host I/O port bus with a 16-bit port address
package vgapr_pkg;
    // ------------------------------------------------------------
    // host port addresses
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_DC_IDX_MONO = 16'h03b4;
    localparam logic [15:0] PORT_DC_DAT_MONO = 16'h03b5;
    localparam logic [15:0] PORT_DC_IDX_COL = 16'h03d4;
    localparam logic [15:0] PORT_DC_DAT_COL = 16'h03d5;
    localparam logic [15:0] PORT_SEQ_INDEX = 16'h03c4;
    localparam logic [15:0] PORT_SEQ_DAT = 16'h03c5;
    localparam logic [15:0] PORT_PIX_MASK = 16'h03c6;
    localparam logic [15:0] PORT_PAL_RIDX = 16'h03c7;
    localparam logic [15:0] PORT_PAL_WIDX = 16'h03c8;
    localparam logic [15:0] PORT_PAL_DATA = 16'h03c9;
    // ------------------------------------------------------------
    // indirect register indices
    // ------------------------------------------------------------
    localparam logic [2:0] SEQ_RESET = 3'h0;
    localparam logic [2:0] SEQ_CLOCK_MODE = 3'h1;
    localparam logic [2:0] SEQ_PLANE_MASK = 3'h2;
    localparam logic [2:0] SEQ_FONT_SEL = 3'h3;
    localparam logic [2:0] SEQ_MEM_MODE = 3'h4;
    localparam logic [5:0] DC_HTOTAL = 6'h00;
    // ------------------------------------------------------------
    // writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_SEQ_RESET = 8'h03;
    localparam logic [7:0] MASK_CLOCK_MODE = 8'h3d;
    localparam logic [7:0] MASK_PLANE = 8'h0f;
    localparam logic [7:0] MASK_FONT = 8'h3f;
    localparam logic [7:0] MASK_MEM_MODE = 8'h0e;
    localparam logic [7:0] RST_SEQ_RESET = 8'h03;
    localparam logic [7:0] RST_CLOCK_MODE = 8'h21;
    localparam logic [7:0] RST_PIX_MASK = 8'hff;
    localparam logic [1:0] PAL_LAST_COMP = 2'h2;
    localparam logic [7:0] PAL_STATE_WRITE = 8'h00;
    localparam logic [7:0] PAL_STATE_READ = 8'h03;
    localparam logic [7:0] HTOTAL_BIAS = 8'h05;

    // decoded sequencer controls towards the display pipeline
    typedef struct packed {
        logic seq_running;
        logic eight_dot_char;
        logic [1:0] load_period_log2;
        logic dot_clock_halve;
        logic screen_off;
        logic [3:0] plane_write_enable;
        logic [2:0] font_a_sel;
        logic [2:0] font_b_sel;
        logic font_select_enable;
        logic odd_even_disable;
        logic chain_four;
    } vgapr_seq_ctrl_t;
endpackage : vgapr_pkg

// ---- hw/vgapr_plane_sel.sv ----
// cpu plane selection from memory mode and plane write mask
// assumes cpu address and plane mask come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module vgapr_plane_sel (
    input wire logic [1:0] cpu_addr_lo_i,
    input wire logic chain_four_i,
    input wire logic odd_even_disable_i,
    input wire logic [3:0] plane_mask_i,
    output logic [3:0] plane_en_o
);
    // chain beats odd/even; only cpu path uses this, display path is untouched
    always_comb begin
        if (chain_four_i) begin
            plane_en_o = 4'h1 << cpu_addr_lo_i; // R18
        end else if (!odd_even_disable_i) begin
            plane_en_o = (cpu_addr_lo_i[0] ? 4'ha : 4'h5) & plane_mask_i; // R17
        end else begin
            plane_en_o = plane_mask_i; // R14
        end
    end
endmodule // vgapr_plane_sel
`default_nettype wire

// ---- hw/vgapr_regs.sv ----
// legacy palette access, pixel mask, sequencer and display-controller ports
// assumes one host i/o access per strobe, synchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - palette data port walks red, green, blue, then moves to next entry
// R2 - palette components travel 6 or 8 bits wide per width enable
// R3 - pixel index ANDed bitwise with mask before lookup; mask resets all ones
// R4 - mask applies only when extended display enable is 0
// R5 - read index write loads pointer; pointer advances after each third read
// R6 - reading read index port gives 0 after write-index, 3 after read-index
// R7 - write index write loads pointer; advances after each third data write
// R8 - three-bit sequencer index picks register for the data port
// R9 - sequencer runs only with both sync reset bits 1; both reset to 1
// R10 - dot-width bit 0 gives 9-dot characters, 1 gives 8; resets to 1
// R11 - serializer loads every clock, every other with bit 2, fourth with bit 4
// R12 - halving bit divides dot clock; software first clears reset bit 0
// R13 - screen-off bit blanks display and frees cpu access; resets to 1
// R14 - four map mask bits gate cpu writes per plane; reset to 0; chain mode here selects its plane without the mask
// R15 - font selectors assembled from split bits of the select register
// R16 - extended memory bit enables font selection, nothing else
// R17 - odd/even clear sends even addresses to planes 0,2, odd to 1,3
// R18 - chain mode picks plane from cpu address bits 1:0, above odd/even
// R19 - software sets odd/even opposite to the graphics mode register bit
// R20 - six-bit display-controller index at mono and colour ports
// R21 - horizontal total is scan line length in characters minus five
// R22 - index registers hold across data-port accesses
// R23 - reserved bits read zero and ignore writes
module vgapr_regs #(
    parameter int PAL_ENTRIES = 256
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // host i/o port
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    // configuration from elsewhere in the device
    input wire logic palette_width_enable_i,
    input wire logic extended_display_enable_i,
    // display pipeline
    input wire logic [7:0] pixel_index_i,
    output logic [7:0] pixel_index_o,
    output vgapr_pkg::vgapr_seq_ctrl_t seq_ctrl_o,
    output logic [7:0] htotal_chars_o,
    // cpu video memory path
    input wire logic [1:0] cpu_addr_lo_i,
    output logic [3:0] cpu_plane_en_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] seq_index;
        logic [7:0] seq_reset;
        logic [7:0] clock_mode;
        logic [7:0] plane_mask;
        logic [7:0] font_sel;
        logic [7:0] mem_mode;
        logic [7:0] dc_index;
        logic [7:0] htotal;
        logic [7:0] pix_mask;
        logic [7:0] pal_ptr;
        logic [1:0] pal_comp;
        logic pal_read_mode;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] pix_out;
        vgapr_pkg::vgapr_seq_ctrl_t ctrl;
        logic [7:0] htotal_chars;
        logic [3:0] plane_en;
    } vgapr_state_t;

    vgapr_state_t state_q;
    vgapr_state_t state_d;
    logic [3:0] plane_sel;
    logic [23:0] pal_mem [PAL_ENTRIES];
    logic [7:0] pal_rd_comp;
    logic [7:0] pal_wr_comp;
    logic pal_wr_en;
    logic [1:0] wr_comp_sel;

    // ------------------------------------------------------------
    // palette storage
    // ------------------------------------------------------------
    // 8-bit components kept; in 6-bit width the low six bits carry the value
    always_comb begin
        pal_rd_comp = 8'h00;
        case (state_q.pal_comp)
            2'h0: pal_rd_comp = pal_mem[state_q.pal_ptr][23:16]; // R1
            2'h1: pal_rd_comp = pal_mem[state_q.pal_ptr][15:8];
            2'h2: pal_rd_comp = pal_mem[state_q.pal_ptr][7:0];
            default: pal_rd_comp = 8'h00;
        endcase
        if (!palette_width_enable_i) begin
            pal_rd_comp = {2'h0, pal_rd_comp[5:0]}; // R2
        end
    end

    assign pal_wr_en = io_wr_i && (io_addr_i == vgapr_pkg::PORT_PAL_DATA);
    assign wr_comp_sel = state_q.pal_comp;
    assign pal_wr_comp = palette_width_enable_i ? io_wdata_i
                                                : {2'h0, io_wdata_i[5:0]}; // R2

    // memory has no reset so that it maps onto plain ram
    always_ff @(posedge core_clk_i) begin
        if (pal_wr_en) begin
            case (wr_comp_sel)
                2'h0: pal_mem[state_q.pal_ptr][23:16] <= pal_wr_comp;
                2'h1: pal_mem[state_q.pal_ptr][15:8] <= pal_wr_comp;
                default: pal_mem[state_q.pal_ptr][7:0] <= pal_wr_comp;
            endcase
        end
    end

    // ------------------------------------------------------------
    // cpu plane selection
    // ------------------------------------------------------------
    vgapr_plane_sel u_plane_sel (
        .cpu_addr_lo_i(cpu_addr_lo_i),
        .chain_four_i(state_q.mem_mode[3]),
        .odd_even_disable_i(state_q.mem_mode[2]),
        .plane_mask_i(state_q.plane_mask[3:0]),
        .plane_en_o(plane_sel)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic dc_idx_hit;
        logic dc_dat_hit;
        logic pal_step;
        logic [7:0] seq_sel_data;
        state_d = state_q;
        dc_idx_hit = (io_addr_i == vgapr_pkg::PORT_DC_IDX_MONO)
                  || (io_addr_i == vgapr_pkg::PORT_DC_IDX_COL); // R20
        dc_dat_hit = (io_addr_i == vgapr_pkg::PORT_DC_DAT_MONO)
                  || (io_addr_i == vgapr_pkg::PORT_DC_DAT_COL);
        pal_step = 1'b0;
        seq_sel_data = 8'h00;

        // indexed sequencer read mux; out-of-range indices read zero
        case (state_q.seq_index[2:0]) // R8
            vgapr_pkg::SEQ_RESET: seq_sel_data = state_q.seq_reset;
            vgapr_pkg::SEQ_CLOCK_MODE: seq_sel_data = state_q.clock_mode;
            vgapr_pkg::SEQ_PLANE_MASK: seq_sel_data = state_q.plane_mask;
            vgapr_pkg::SEQ_FONT_SEL: seq_sel_data = state_q.font_sel;
            vgapr_pkg::SEQ_MEM_MODE: seq_sel_data = state_q.mem_mode;
            default: seq_sel_data = 8'h00;
        endcase

        // host writes; only masked bits stick
        if (io_wr_i) begin
            case (io_addr_i)
                vgapr_pkg::PORT_SEQ_INDEX: begin
                    state_d.seq_index = {5'h00, io_wdata_i[2:0]}; // R23
                end
                vgapr_pkg::PORT_SEQ_DAT: begin
                    case (state_q.seq_index[2:0]) // R22
                        vgapr_pkg::SEQ_RESET:
                            state_d.seq_reset = io_wdata_i & vgapr_pkg::MASK_SEQ_RESET;
                        vgapr_pkg::SEQ_CLOCK_MODE:
                            state_d.clock_mode = io_wdata_i & vgapr_pkg::MASK_CLOCK_MODE;
                        vgapr_pkg::SEQ_PLANE_MASK:
                            state_d.plane_mask = io_wdata_i & vgapr_pkg::MASK_PLANE;
                        vgapr_pkg::SEQ_FONT_SEL:
                            state_d.font_sel = io_wdata_i & vgapr_pkg::MASK_FONT;
                        vgapr_pkg::SEQ_MEM_MODE:
                            state_d.mem_mode = io_wdata_i & vgapr_pkg::MASK_MEM_MODE;
                        default: ;
                    endcase
                end
                vgapr_pkg::PORT_PIX_MASK: state_d.pix_mask = io_wdata_i;
                vgapr_pkg::PORT_PAL_RIDX: begin
                    state_d.pal_ptr = io_wdata_i; // R5
                    state_d.pal_comp = 2'h0;
                    state_d.pal_read_mode = 1'b1;
                end
                vgapr_pkg::PORT_PAL_WIDX: begin
                    state_d.pal_ptr = io_wdata_i; // R7
                    state_d.pal_comp = 2'h0;
                    state_d.pal_read_mode = 1'b0;
                end
                vgapr_pkg::PORT_PAL_DATA: pal_step = 1'b1; // R7
                default: begin
                    if (dc_idx_hit) begin
                        state_d.dc_index = {2'h0, io_wdata_i[5:0]}; // R23
                    end else if (dc_dat_hit
                            && state_q.dc_index[5:0] == vgapr_pkg::DC_HTOTAL) begin
                        state_d.htotal = io_wdata_i; // R22
                    end
                end
            endcase
        end

        // host reads answer one cycle later; unmapped ports read zero
        state_d.rvalid = io_rd_i;
        if (io_rd_i) begin
            state_d.rdata = 8'h00;
            case (io_addr_i)
                vgapr_pkg::PORT_SEQ_INDEX: state_d.rdata = state_q.seq_index;
                vgapr_pkg::PORT_SEQ_DAT: state_d.rdata = seq_sel_data;
                vgapr_pkg::PORT_PIX_MASK: state_d.rdata = state_q.pix_mask;
                vgapr_pkg::PORT_PAL_RIDX: begin
                    state_d.rdata = state_q.pal_read_mode ? vgapr_pkg::PAL_STATE_READ
                                                          : vgapr_pkg::PAL_STATE_WRITE; // R6
                end
                vgapr_pkg::PORT_PAL_WIDX: state_d.rdata = state_q.pal_ptr;
                vgapr_pkg::PORT_PAL_DATA: begin
                    state_d.rdata = pal_rd_comp; // R5
                    pal_step = 1'b1;
                end
                default: begin
                    if (dc_idx_hit) begin
                        state_d.dc_index = state_q.dc_index;
                        state_d.rdata = state_q.dc_index;
                    end else if (dc_dat_hit
                            && state_q.dc_index[5:0] == vgapr_pkg::DC_HTOTAL) begin
                        state_d.rdata = state_q.htotal;
                    end
                end
            endcase
        end

        // component walk: after blue the entry pointer moves on
        if (pal_step) begin
            if (state_q.pal_comp == vgapr_pkg::PAL_LAST_COMP) begin
                state_d.pal_comp = 2'h0;
                state_d.pal_ptr = state_q.pal_ptr + 8'h01; // R1
            end else begin
                state_d.pal_comp = state_q.pal_comp + 2'h1;
            end
        end

        // pixel path: mask only in emulation modes
        state_d.pix_out = extended_display_enable_i ? pixel_index_i
                        : (pixel_index_i & state_q.pix_mask); // R3 R4

        // decoded sequencer controls
        state_d.ctrl.seq_running = state_q.seq_reset[0] & state_q.seq_reset[1]; // R9
        state_d.ctrl.eight_dot_char = state_q.clock_mode[0]; // R10
        if (state_q.clock_mode[4]) begin
            state_d.ctrl.load_period_log2 = 2'h2; // R11
        end else if (state_q.clock_mode[2]) begin
            state_d.ctrl.load_period_log2 = 2'h1;
        end else begin
            state_d.ctrl.load_period_log2 = 2'h0;
        end
        // halving is passed on as set; software holds reset bit 0 low meanwhile
        state_d.ctrl.dot_clock_halve = state_q.clock_mode[3]; // R12
        state_d.ctrl.screen_off = state_q.clock_mode[5]; // R13
        state_d.ctrl.plane_write_enable = state_q.plane_mask[3:0]; // R14
        state_d.ctrl.font_b_sel = {state_q.font_sel[1], state_q.font_sel[0],
                                   state_q.font_sel[4]}; // R15
        state_d.ctrl.font_a_sel = {state_q.font_sel[3], state_q.font_sel[2],
                                   state_q.font_sel[5]}; // R15
        state_d.ctrl.font_select_enable = state_q.mem_mode[1]; // R16
        state_d.ctrl.odd_even_disable = state_q.mem_mode[2]; // R19
        state_d.ctrl.chain_four = state_q.mem_mode[3];
        state_d.htotal_chars = state_q.htotal + vgapr_pkg::HTOTAL_BIAS; // R21
        state_d.plane_en = plane_sel; // R17 R18
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset values match the control defaults the display path expects
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
            state_q.seq_reset <= vgapr_pkg::RST_SEQ_RESET; // R9
            state_q.clock_mode <= vgapr_pkg::RST_CLOCK_MODE; // R10 R13
            state_q.pix_mask <= vgapr_pkg::RST_PIX_MASK; // R3
            state_q.ctrl.seq_running <= 1'b1;
            state_q.ctrl.eight_dot_char <= 1'b1;
            state_q.ctrl.screen_off <= 1'b1;
            state_q.htotal_chars <= vgapr_pkg::HTOTAL_BIAS;
        end else begin
            state_q <= state_d;
        end
    end

    assign io_rdata_o = state_q.rdata;
    assign io_rvalid_o = state_q.rvalid;
    assign pixel_index_o = state_q.pix_out;
    assign seq_ctrl_o = state_q.ctrl;
    assign htotal_chars_o = state_q.htotal_chars;
    assign cpu_plane_en_o = state_q.plane_en;
endmodule // vgapr_regs
`default_nettype wire

// ---- verif/vgapr_host_model.sv ----
// host processor model issuing legacy port reads and writes
// assumes the block answers a read exactly one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none
module vgapr_host_model (
    input wire logic core_clk_i,
    input wire logic io_rvalid_o,
    input wire logic [7:0] io_rdata_o,
    output logic io_rd_i,
    output logic io_wr_i,
    output logic [15:0] io_addr_i,
    output logic [7:0] io_wdata_i
);
    initial begin
        io_rd_i = 1'b0;
        io_wr_i = 1'b0;
        io_addr_i = 16'h0000;
        io_wdata_i = 8'h00;
    end
    // write stays up so writes can run back to back
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        io_wr_i <= 1'b1;
        io_rd_i <= 1'b0;
        io_addr_i <= a;
        io_wdata_i <= d;
    endtask
    // released lines flip so a stale value is never mistaken for data
    task automatic idle();
        @(posedge core_clk_i);
        io_wr_i <= 1'b0;
        io_rd_i <= 1'b0;
        io_addr_i <= ~io_addr_i;
        io_wdata_i <= ~io_wdata_i;
    endtask
    // a missing answer returns unknown so the caller's compare fails
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        io_wr_i <= 1'b0;
        io_rd_i <= 1'b1;
        io_addr_i <= a;
        io_wdata_i <= ~io_wdata_i;
        idle();
        #1;
        d = (io_rvalid_o === 1'b1) ? io_rdata_o : 8'hxx;
    endtask
endmodule // vgapr_host_model
`default_nettype wire

// ---- verif/vgapr_regs_bench.sv ----
// self-checking bench for the palette/sequencer register block
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none
module vgapr_regs_bench;
    logic core_clk_i, rst_n_i, io_rd_i, io_wr_i, io_rvalid_o;
    logic palette_width_enable_i, extended_display_enable_i;
    logic [15:0] io_addr_i;
    logic [7:0] io_wdata_i, io_rdata_o, pixel_index_i, pixel_index_o, htotal_chars_o;
    logic [1:0] cpu_addr_lo_i;
    logic [3:0] cpu_plane_en_o;
    vgapr_pkg::vgapr_seq_ctrl_t seq_ctrl_o;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    vgapr_regs vgapr_regs_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
        .palette_width_enable_i(palette_width_enable_i),
        .extended_display_enable_i(extended_display_enable_i),
        .pixel_index_i(pixel_index_i), .pixel_index_o(pixel_index_o),
        .seq_ctrl_o(seq_ctrl_o), .htotal_chars_o(htotal_chars_o),
        .cpu_addr_lo_i(cpu_addr_lo_i), .cpu_plane_en_o(cpu_plane_en_o));
    vgapr_host_model host (.core_clk_i(core_clk_i), .io_rvalid_o(io_rvalid_o),
        .io_rdata_o(io_rdata_o), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i));

    // ----------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        check(v, exp);
    endtask
    task automatic seq_wr(input logic [7:0] idx, input logic [7:0] d);
        host.wr(16'h03c4, idx);
        host.wr(16'h03c5, d);
    endtask
    // decoded outputs lag a taken write by two cycles
    task automatic settle();
        host.idle();
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        logic [7:0] exp [5] = '{8'h03, 8'h21, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            host.wr(16'h03c4, 8'(i));
            rd_chk(16'h03c5, exp[i]);
        end
        rd_chk(16'h03c6, 8'hff);
        rd_chk(16'h03c7, 8'h00);
        check(htotal_chars_o, 8'h05);
        check(8'(seq_ctrl_o.seq_running), 8'h01);
    endtask
    // pointer starts at the last entry to see the wrap to entry 0
    task automatic t_palette();
        @(posedge core_clk_i);
        palette_width_enable_i <= 1'b1;
        host.wr(16'h03c8, 8'hff);
        for (int i = 0; i < 6; i++) host.wr(16'h03c9, 8'h80 + 8'(i));
        rd_chk(16'h03c7, 8'h00);
        host.wr(16'h03c7, 8'hff);
        rd_chk(16'h03c7, 8'h03);
        for (int i = 0; i < 6; i++) rd_chk(16'h03c9, 8'h80 + 8'(i));
        @(posedge core_clk_i);
        palette_width_enable_i <= 1'b0;
        host.wr(16'h03c8, 8'h10);
        for (int i = 0; i < 3; i++) host.wr(16'h03c9, 8'hff);
        host.wr(16'h03c7, 8'h10);
        rd_chk(16'h03c9, 8'h3f);
        @(posedge core_clk_i);
        palette_width_enable_i <= 1'b1;
        rd_chk(16'h03c9, 8'h3f);
    endtask
    task automatic t_mask();
        host.wr(16'h03c6, 8'h0f);
        host.idle();
        @(posedge core_clk_i);
        pixel_index_i <= 8'hab;
        repeat (2) @(posedge core_clk_i);
        #1 check(pixel_index_o, 8'h0b);
        @(posedge core_clk_i);
        extended_display_enable_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 check(pixel_index_o, 8'hab);
    endtask
    task automatic t_seq();
        logic [7:0] rst_v [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
        seq_wr(8'h00, 8'h02);
        seq_wr(8'hf9, 8'hff);
        rd_chk(16'h03c5, 8'h3d);
        rd_chk(16'h03c5, 8'h3d);
        rd_chk(16'h03c4, 8'h01);
        settle();
        check(8'(seq_ctrl_o.load_period_log2), 8'h02);
        check(8'(seq_ctrl_o.dot_clock_halve), 8'h01);
        seq_wr(8'h01, 8'h04);
        settle();
        check(8'(seq_ctrl_o.load_period_log2), 8'h01);
        check(8'(seq_ctrl_o.eight_dot_char), 8'h00);
        check(8'(seq_ctrl_o.screen_off), 8'h00);
        for (int i = 0; i < 4; i++) begin
            seq_wr(8'h00, rst_v[i]);
            settle();
            check(8'(seq_ctrl_o.seq_running), 8'(rst_v[i] == 8'h03));
        end
        @(posedge core_clk_i);
        cpu_addr_lo_i <= 2'h1;
        seq_wr(8'h03, 8'h39);
        seq_wr(8'h04, 8'h02);
        seq_wr(8'h02, 8'h0f);
        settle();
        check(8'(seq_ctrl_o.font_a_sel), 8'h05);
        check(8'(seq_ctrl_o.font_b_sel), 8'h03);
        check(8'(seq_ctrl_o.font_select_enable), 8'h01);
        check(8'(cpu_plane_en_o), 8'h0a);
        seq_wr(8'h04, 8'h0a);
        settle();
        check(8'(cpu_plane_en_o), 8'h02);
        seq_wr(8'h02, 8'h06);
        seq_wr(8'h04, 8'h04);
        settle();
        check(8'(cpu_plane_en_o), 8'h06);
        check(8'(seq_ctrl_o.plane_write_enable), 8'h06);
        seq_wr(8'h05, 8'hff);
        rd_chk(16'h03c5, 8'h00);
    endtask
    task automatic t_crtc();
        host.wr(16'h03d4, 8'hc0);
        host.wr(16'h03b5, 8'h5a);
        rd_chk(16'h03d5, 8'h5a);
        rd_chk(16'h03b4, 8'h00);
        settle();
        check(htotal_chars_o, 8'h5f);
        host.wr(16'h03b4, 8'h01);
        host.wr(16'h03b5, 8'h77);
        rd_chk(16'h03d5, 8'h00);
        host.wr(16'h03d4, 8'h00);
        host.wr(16'h03d5, 8'hfe);
        settle();
        check(htotal_chars_o, 8'h03);
        rd_chk(16'h0300, 8'h00);
    endtask

    // ----------------------------------------------------------
    // clock, hang guard and main sequence
    // ----------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        palette_width_enable_i = 1'b1;
        extended_display_enable_i = 1'b0;
        pixel_index_i = 8'h00;
        cpu_addr_lo_i = 2'h0;
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_palette();
        t_mask();
        t_seq();
        t_crtc();
        tally_and_finish();
    end
endmodule // vgapr_regs_bench

bind vgapr_regs vgapr_regs_monitor vgapr_regs_monitor_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .extended_display_enable_i(extended_display_enable_i),
    .pixel_index_i(pixel_index_i), .pixel_index_o(pixel_index_o),
    .seq_ctrl_o(seq_ctrl_o), .htotal_chars_o(htotal_chars_o),
    .cpu_addr_lo_i(cpu_addr_lo_i), .cpu_plane_en_o(cpu_plane_en_o));
`default_nettype wire

// ---- verif/vgapr_regs_monitor.sv ----
// checker for the palette/sequencer register block ports
// assumes it is bound onto vgapr_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module vgapr_regs_monitor (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic extended_display_enable_i,
    input wire logic [7:0] pixel_index_i,
    input wire logic [7:0] pixel_index_o,
    input wire vgapr_pkg::vgapr_seq_ctrl_t seq_ctrl_o,
    input wire logic [7:0] htotal_chars_o,
    input wire logic [1:0] cpu_addr_lo_i,
    input wire logic [3:0] cpu_plane_en_o
);
    // ----------------------------------------------------------
    // one clock domain, so clock and disable are stated once
    // ----------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_read_answer: assert property (io_rvalid_o == $past(io_rd_i))
        else $error("read answer not exactly one cycle after strobe");
    a_rdata_holds: assert property (!$past(io_rd_i) |-> $stable(io_rdata_o))
        else $error("read data moved without a read");
    a_mask_bypass: assert property ($past(extended_display_enable_i)
        |-> pixel_index_o == $past(pixel_index_i))
        else $error("pixel mask applied in extended mode");
    a_chain_plane: assert property (seq_ctrl_o.chain_four
        |-> cpu_plane_en_o == 4'h1 << $past(cpu_addr_lo_i))
        else $error("chain plane select wrong");
    a_odd_even: assert property (!seq_ctrl_o.chain_four && !seq_ctrl_o.odd_even_disable
        |-> cpu_plane_en_o == (($past(cpu_addr_lo_i[0]) ? 4'ha : 4'h5)
        & seq_ctrl_o.plane_write_enable))
        else $error("odd/even plane select wrong");
    a_plane_mask: assert property (!seq_ctrl_o.chain_four && seq_ctrl_o.odd_even_disable
        |-> cpu_plane_en_o == seq_ctrl_o.plane_write_enable)
        else $error("plane mask not applied");
    a_load_code: assert property (seq_ctrl_o.load_period_log2 != 2'h3)
        else $error("illegal serializer load period");
    a_run_cause: assert property ($changed(seq_ctrl_o.seq_running) |-> $past(io_wr_i, 2))
        else $error("run state moved without a write");
    a_htotal_cause: assert property ($changed(htotal_chars_o) |-> $past(io_wr_i, 2))
        else $error("horizontal total moved without a write");
endmodule // vgapr_regs_monitor
`default_nettype wire
